/* hw/rwdc_params.svh */
/*
 Constants of the reset and watchdog controller: offsets, field positions,
 reset values and timing counts. Assumes a 125 MHz system clock.
*/
// Notes on behaviour
// - Reset clears control registers; core restarts afterwards.
// - I/O reset follows pin sources without any clock; brown-out and watchdog come through flops.
// - Fuse-selected delay stretches internal reset after sources.
// - Five sources: supply, pin, watchdog, brown-out, scan.
// - Pin low beyond minimum width causes reset.
// - Supply loss reasserts at once; rise starts delay.
// - Enabled brown-out asserts reset; recovery starts delay.
// - Brown-out dips shorter than detect time ignored.
// - Scan reset bit holds reset while one.
// - Watchdog reset is one-cycle pulse, then delay.
// - Watchdog counts its own slow oscillator.
// - Restart clears counter; else time-out acts.
// - Interrupt mode expiry raises wake-capable interrupt.
// - Combined mode: interrupt first, then reset mode.
// - Always-on fuse forces reset mode, irq off.
// - Step one writes change and reset enables.
// - Within four cycles, one write changes fields.
// - Time-out selectable from 16 ms to 8 s.
// - Watchdog stays enabled after a watchdog reset.
// - Watchdog reset flag forces reset enable on.
// - Change enable self-clears after four cycles.
// - Irq flag cleared by vector or writing one.
`ifndef RWDC_PARAMS_SVH
`define RWDC_PARAMS_SVH

`define RWDC_ADDR_WDCTL   4'h0
`define RWDC_ADDR_RSTFLG  4'h1

`define RWDC_WDCTL_IRQF   7
`define RWDC_WDCTL_IRQE   6
`define RWDC_WDCTL_PS3    5
`define RWDC_WDCTL_CE     4
`define RWDC_WDCTL_RE     3

`define RWDC_FLG_SCAN     3'd4
`define RWDC_FLG_WD       3'd3
`define RWDC_FLG_BOD      3'd2
`define RWDC_FLG_EXT      3'd1
`define RWDC_FLG_POR      3'd0

`define RWDC_PS_RST       4'h0
`define RWDC_PS_MAX       4'h9
`define RWDC_RSTFLG_RST   5'h01
`define RWDC_BOD_OFF      3'h7

`define RWDC_CE_WIN_CYC   3'h4
`define RWDC_WD_BASE_CYC  21'h000800
`define RWDC_MCLK_MHZ     125
`define RWDC_EXT_MIN_NS   1000
`define RWDC_BOD_MIN_NS   2000
`define RWDC_EXT_MIN_CYC  ((`RWDC_EXT_MIN_NS * `RWDC_MCLK_MHZ + 999) / 1000)
`define RWDC_BOD_MIN_CYC  ((`RWDC_BOD_MIN_NS * `RWDC_MCLK_MHZ + 999) / 1000)

`endif

/* hw/rwdc_pkg.sv */
/*
 Types of the reset and watchdog controller: watchdog modes and the
 reset sequencer states. Assumes nothing of its surroundings.
*/
package rwdc_pkg;

    // Watchdog action on time-out
    typedef enum logic [3:0] {
        WD_STOP = 4'h1,
        WD_IRQ  = 4'h2,
        WD_RST  = 4'h4,
        WD_BOTH = 4'h8
    } rwdc_wd_mode_t;

    // Internal reset sequencer
    typedef enum logic [2:0] {
        RS_HOLD  = 3'h1,
        RS_DELAY = 3'h2,
        RS_RUN   = 3'h4
    } rwdc_rst_state_t;

endpackage : rwdc_pkg

/* hw/rwdc_top.sv */
/*
 Reset controller with watchdog timer. Combines the reset sources,
 stretches the internal reset and runs the watchdog with its protected
 control register. Assumes pins and fuses are asynchronous to mclk_i,
 the slow watchdog oscillator is far slower than mclk_i, and the
 register port and restart/ack strobes are synchronous to mclk_i.
*/
`timescale 1ns/100ps
`include "rwdc_params.svh"

module rwdc_top #(
    parameter int unsigned DLY_UNIT_CYC = 8192
) (
    input  wire logic       mclk_i,
    input  wire logic       nrst_i,
    input  wire logic       por_i,
    input  wire logic       ext_rst_n_i,
    input  wire logic       bod_low_i,
    input  wire logic       scan_rst_i,
    input  wire logic       wd_osc_i,
    input  wire logic [2:0] brownout_level_fuse_i,
    input  wire logic [1:0] startup_time_fuse_i,
    input  wire logic [3:0] clock_select_fuse_i,
    input  wire logic       wd_always_on_fuse_i,
    input  wire logic       wd_restart_i,
    input  wire logic       wd_irq_ack_i,
    input  wire logic [3:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    output logic            io_rst_o,
    output logic            sys_rst_o,
    output logic            wd_irq_o
);
    import rwdc_pkg::*;

    localparam int SW = 15;
    localparam logic [11:0] EXT_MIN_CYC = 12'(`RWDC_EXT_MIN_CYC);
    localparam logic [11:0] BOD_MIN_CYC = 12'(`RWDC_BOD_MIN_CYC);

    logic [SW-1:0]   pin_raw;
    logic [SW-1:0]   sync1_r;
    logic [SW-1:0]   sync2_r;
    logic            por_s;
    logic            extn_s;
    logic            bodl_s;
    logic            scan_s;
    logic            osc_s;
    logic [2:0]      bodlvl_s;
    logic [1:0]      sut_s;
    logic [3:0]      clock_select_fuse_s;
    logic            aon_s;
    logic            osc_d_r;
    logic            tick;
    logic [11:0]     ext_cnt_r;
    logic            ext_acc_r;
    logic [11:0]     bod_cnt_r;
    logic            bod_acc_r;
    logic            bod_en;
    logic            srcs;
    logic            wd_rst_pulse_r;
    rwdc_rst_state_t rs_state_r;
    logic [23:0]     dly_cnt_r;
    logic [23:0]     dly_lim;
    logic [2:0]      dly_sel;
    logic            sys_rst_r;
    logic            ctrl_rst;
    logic            irqf_r;
    logic            irqe_r;
    logic            re_r;
    logic            re_eff;
    logic [3:0]      ps_r;
    logic [3:0]      ps_use;
    logic [2:0]      ce_win_r;
    logic            ce;
    logic            wr_ctl;
    logic            wr_flg;
    logic            step1;
    logic            in_win;
    rwdc_wd_mode_t   mode;
    logic [20:0]     wd_cnt_r;
    logic [20:0]     wd_lim;
    logic            timeout;
    logic            to_irq;
    logic            to_rst;
    logic [4:0]      rflag_r;
    logic [4:0]      flg_set;
    logic [4:0]      flg_clr;
    logic            flag_wd;
    logic [7:0]      rdata_r;
    logic            wd_irq_r;

    // Every pin and fuse passes two flops before use, save the raw pin terms of io_rst_o
    assign pin_raw = {por_i, ext_rst_n_i, bod_low_i, scan_rst_i, wd_osc_i,
                      brownout_level_fuse_i, startup_time_fuse_i,
                      clock_select_fuse_i, wd_always_on_fuse_i};

    generate
        for (genvar g = 0; g < SW; g++) begin : g_sync
            always_ff @(posedge mclk_i) begin
                if (!nrst_i) begin
                    sync1_r[g] <= 1'b0;
                    sync2_r[g] <= 1'b0;
                end else begin
                    sync1_r[g] <= pin_raw[g];
                    sync2_r[g] <= sync1_r[g];
                end
            end
        end
    endgenerate

    // Field view of the synchronised pins
    assign por_s    = sync2_r[14];
    assign extn_s   = sync2_r[13];
    assign bodl_s   = sync2_r[12];
    assign scan_s   = sync2_r[11];
    assign osc_s    = sync2_r[10];
    assign bodlvl_s = sync2_r[9:7];
    assign sut_s    = sync2_r[6:5];
    assign clock_select_fuse_s  = sync2_r[4:1];
    assign aon_s    = sync2_r[0];

    // Rising edge of the slow oscillator gives the watchdog tick
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            osc_d_r <= 1'b0;
        end else begin
            osc_d_r <= osc_s;
        end
    end
    assign tick = osc_s & ~osc_d_r;

    // Reset pin must stay low for the minimum width to count
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            ext_cnt_r <= 12'h000;
            ext_acc_r <= 1'b0;
        end else if (extn_s) begin
            ext_cnt_r <= 12'h000;
            ext_acc_r <= 1'b0;
        end else if (ext_cnt_r == EXT_MIN_CYC) begin
            ext_acc_r <= 1'b1;
        end else begin
            ext_cnt_r <= ext_cnt_r + 12'h001;
        end
    end

    // Brown-out filter; short dips never reach the reset tree
    assign bod_en = (bodlvl_s != `RWDC_BOD_OFF);

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            bod_cnt_r <= 12'h000;
            bod_acc_r <= 1'b0;
        end else if (!(bodl_s && bod_en)) begin
            bod_cnt_r <= 12'h000;
            bod_acc_r <= 1'b0;
        end else if (bod_cnt_r == BOD_MIN_CYC) begin
            bod_acc_r <= 1'b1;
        end else begin
            bod_cnt_r <= bod_cnt_r + 12'h001;
        end
    end

    // Path to the ports; pins unclocked, brown-out and watchdog terms from flops
    assign io_rst_o = ~nrst_i | por_i | ~ext_rst_n_i | scan_rst_i
                    | bod_acc_r | wd_rst_pulse_r;

    // OR of the five sources
    assign srcs = por_s | ext_acc_r | bod_acc_r | scan_s
                | wd_rst_pulse_r;

    // Delay length from start-up and clock-select fuses
    assign dly_sel = {clock_select_fuse_s[3], sut_s};
    assign dly_lim = 24'(DLY_UNIT_CYC) << dly_sel;

    // Sequencer: hold while any source, then stretch, then run
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            rs_state_r <= RS_HOLD;
            dly_cnt_r  <= 24'h000000;
            sys_rst_r  <= 1'b1;
        end else if (srcs) begin
            rs_state_r <= RS_HOLD;
            dly_cnt_r  <= 24'h000000;
            sys_rst_r  <= 1'b1;
        end else begin
            unique case (rs_state_r)
                RS_HOLD: begin
                    rs_state_r <= RS_DELAY;
                    dly_cnt_r  <= 24'h000000;
                end
                RS_DELAY: begin
                    if (dly_cnt_r >= dly_lim - 24'h000001) begin
                        rs_state_r <= RS_RUN;
                        sys_rst_r  <= 1'b0;
                    end else begin
                        dly_cnt_r <= dly_cnt_r + 24'h000001;
                    end
                end
                RS_RUN: begin
                    sys_rst_r <= 1'b0;
                end
            endcase
        end
    end

    // Control registers return to initial values under internal reset
    assign ctrl_rst = ~nrst_i | sys_rst_r;

    // Register port decode
    assign wr_ctl  = reg_wr_i && (reg_addr_i == `RWDC_ADDR_WDCTL);
    assign wr_flg  = reg_wr_i && (reg_addr_i == `RWDC_ADDR_RSTFLG);
    assign ce      = (ce_win_r != 3'h0);
    assign step1   = wr_ctl && reg_wdata_i[`RWDC_WDCTL_CE]
                  && reg_wdata_i[`RWDC_WDCTL_RE];
    assign in_win  = wr_ctl && ce && !reg_wdata_i[`RWDC_WDCTL_CE];
    assign flag_wd = rflag_r[`RWDC_FLG_WD];
    assign re_eff  = re_r | flag_wd | aon_s;

    // Change window: opens on step one, shuts after four cycles or a use
    always_ff @(posedge mclk_i) begin
        if (ctrl_rst) begin
            ce_win_r <= 3'h0;
        end else if (step1) begin
            ce_win_r <= `RWDC_CE_WIN_CYC;
        end else if (in_win) begin
            ce_win_r <= 3'h0;
        end else if (ce) begin
            ce_win_r <= ce_win_r - 3'h1;
        end
    end

    // Reset enable: set freely, cleared only inside the window
    always_ff @(posedge mclk_i) begin
        if (ctrl_rst) begin
            re_r <= 1'b0;
        end else if (aon_s || flag_wd) begin
            re_r <= 1'b1;
        end else if (in_win) begin
            re_r <= reg_wdata_i[`RWDC_WDCTL_RE];
        end else if (wr_ctl && reg_wdata_i[`RWDC_WDCTL_RE]) begin
            re_r <= 1'b1;
        end
    end

    // Prescale changes only inside the window
    always_ff @(posedge mclk_i) begin
        if (ctrl_rst) begin
            ps_r <= `RWDC_PS_RST;
        end else if (in_win) begin
            ps_r <= {reg_wdata_i[`RWDC_WDCTL_PS3], reg_wdata_i[2:0]};
        end
    end

    // Interrupt enable; hardware clear beats a software write
    always_ff @(posedge mclk_i) begin
        if (ctrl_rst || aon_s) begin
            irqe_r <= 1'b0;
        end else if (to_irq && (mode == WD_BOTH)) begin
            irqe_r <= 1'b0;
        end else if (wd_irq_ack_i && re_eff) begin
            irqe_r <= 1'b0;
        end else if (wr_ctl) begin
            irqe_r <= reg_wdata_i[`RWDC_WDCTL_IRQE];
        end
    end

    // Mode from the effective enables
    always_comb begin
        if (aon_s || (re_eff && !irqe_r)) begin
            mode = WD_RST;
        end else if (re_eff && irqe_r) begin
            mode = WD_BOTH;
        end else if (irqe_r) begin
            mode = WD_IRQ;
        end else begin
            mode = WD_STOP;
        end
    end

    // Reserved prescale codes behave as the longest period
    assign ps_use = (ps_r > `RWDC_PS_MAX) ? `RWDC_PS_MAX : ps_r;
    assign wd_lim = `RWDC_WD_BASE_CYC << ps_use;

    // Greater-or-equal guards a switch to a shorter period
    assign timeout = tick && (mode != WD_STOP)
                  && (wd_cnt_r >= wd_lim - 21'h000001);

    // Watchdog counter on oscillator ticks, cleared by restart
    always_ff @(posedge mclk_i) begin
        if (ctrl_rst || wd_restart_i || (mode == WD_STOP)) begin
            wd_cnt_r <= 21'h000000;
        end else if (timeout) begin
            wd_cnt_r <= 21'h000000;
        end else if (tick) begin
            wd_cnt_r <= wd_cnt_r + 21'h000001;
        end
    end

    // Time-out action per mode
    always_comb begin
        to_irq = 1'b0;
        to_rst = 1'b0;
        unique case (mode)
            WD_STOP: begin
            end
            WD_IRQ: begin
                to_irq = timeout;
            end
            WD_RST: begin
                to_rst = timeout;
            end
            WD_BOTH: begin
                to_irq = timeout;
            end
        endcase
    end

    // One-cycle internal reset pulse on a reset-mode time-out
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            wd_rst_pulse_r <= 1'b0;
        end else begin
            wd_rst_pulse_r <= to_rst && !sys_rst_r;
        end
    end

    // Interrupt flag: set wins over vector or write-one clear
    always_ff @(posedge mclk_i) begin
        if (ctrl_rst) begin
            irqf_r <= 1'b0;
        end else if (to_irq) begin
            irqf_r <= 1'b1;
        end else if (wd_irq_ack_i || (wr_ctl && reg_wdata_i[`RWDC_WDCTL_IRQF])) begin
            irqf_r <= 1'b0;
        end
    end

    // Reset cause flags survive the internal reset; supply loss leaves only the power-on flag
    assign flg_set = {scan_s, wd_rst_pulse_r, bod_acc_r, ext_acc_r, 1'b0};
    assign flg_clr = wr_flg ? ~reg_wdata_i[4:0] : 5'h00;

    always_ff @(posedge mclk_i) begin
        if (!nrst_i || por_s) begin
            rflag_r <= `RWDC_RSTFLG_RST;
        end else begin
            rflag_r <= (rflag_r & ~flg_clr) | flg_set;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge mclk_i) begin
        if (!nrst_i || !reg_rd_i) begin
            rdata_r <= 8'h00;
        end else if (reg_addr_i == `RWDC_ADDR_WDCTL) begin
            rdata_r <= {irqf_r, irqe_r, ps_r[3], ce, re_eff, ps_r[2:0]};
        end else if (reg_addr_i == `RWDC_ADDR_RSTFLG) begin
            rdata_r <= {3'h0, rflag_r};
        end else begin
            rdata_r <= 8'h00;
        end
    end

    // Interrupt request, also used as wake-up
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            wd_irq_r <= 1'b0;
        end else begin
            wd_irq_r <= irqf_r;
        end
    end

    assign reg_rdata_o = rdata_r;
    assign sys_rst_o   = sys_rst_r;
    assign wd_irq_o    = wd_irq_r;

endmodule : rwdc_top

/* dv/rwdc_osc_model.sv */
/*
 Slow watchdog oscillator beside the controller.
 Assumes the half period spans several system clock periods.
*/
`timescale 1ns/100ps

module rwdc_osc_model #(
    parameter int HALF_NS = 24
) (
    output logic osc_o
);
    // Free-running, phase unrelated to the system clock
    initial begin
        osc_o = 1'b0;
        #7;
        forever #(HALF_NS) osc_o = ~osc_o;
    end
endmodule : rwdc_osc_model

/* dv/rwdc_top_props.sv */
/*
 Port checker of the reset and watchdog controller.
 Assumes a bind into rwdc_top with the same delay unit.
*/
`timescale 1ns/100ps

module rwdc_top_props #(
    parameter int unsigned DLY_UNIT_CYC = 8192
) (
    input wire logic       mclk_i,
    input wire logic       nrst_i,
    input wire logic       por_i,
    input wire logic       ext_rst_n_i,
    input wire logic       scan_rst_i,
    input wire logic       wd_always_on_fuse_i,
    input wire logic       wd_irq_ack_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       io_rst_o,
    input wire logic       sys_rst_o,
    input wire logic       wd_irq_o
);
    int unsigned quiet_r;
    logic        ctl_rd;
    logic        ce_open;

    // Quiet cycles since the last source; saturates to stay cheap
    always_ff @(posedge mclk_i) begin
        if (io_rst_o)
            quiet_r <= 32'h0;
        else if (quiet_r < 32'hffff)
            quiet_r <= quiet_r + 32'h1;
    end

    // Control reads and window-opening writes
    assign ctl_rd  = reg_rd_i && reg_addr_i == 4'h0;
    assign ce_open = reg_wr_i && reg_addr_i == 4'h0 && reg_wdata_i[4:3] == 2'h3 && !sys_rst_o;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);

    a_reset_state: assert property (disable iff (1'b0)
        !nrst_i |=> sys_rst_o && !wd_irq_o && reg_rdata_o == 8'h00)
        else $error("outputs not held by reset");
    a_src_io: assert property ((por_i || scan_rst_i || !ext_rst_n_i) |-> io_rst_o)
        else $error("io reset missed a source");
    a_scan_hold: assert property (scan_rst_i [*5] |-> sys_rst_o)
        else $error("scan reset not held");
    a_por_hold: assert property (por_i [*5] |-> sys_rst_o)
        else $error("power-on reset not held");
    a_late_release: assert property ($fell(sys_rst_o) |-> quiet_r >= DLY_UNIT_CYC)
        else $error("internal reset released early");
    a_unmapped_zero: assert property (
        $past(reg_rd_i) && $past(reg_addr_i) > 4'h1 |-> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_window_open: assert property (ce_open ##1 ctl_rd |=> reg_rdata_o[4])
        else $error("change enable not set");
    // Four quiet cycles exactly: a longer window must fail here
    a_window_shut: assert property (
        ce_open ##1 (!reg_wr_i) [*4] ##1 ctl_rd |=> !reg_rdata_o[4])
        else $error("change enable stuck");
    a_irq_mirror: assert property ($past(ctl_rd) |-> reg_rdata_o[7] == wd_irq_o)
        else $error("irq output differs from flag");
    // Fuse reaches the read data through two sync stages and one flop
    a_fuse_lock: assert property (
        $past(wd_always_on_fuse_i, 3) && $past(wd_always_on_fuse_i, 4) && $past(ctl_rd)
        |-> reg_rdata_o[3] && !reg_rdata_o[6])
        else $error("fuse lock broken");
    a_ack_clears: assert property (wd_irq_ack_i && wd_irq_o |-> ##2 !wd_irq_o)
        else $error("ack left irq up");

    c_window: cover property (ce_open);
    c_irq_rise: cover property ($rose(wd_irq_o));
    c_rst_rise: cover property ($rose(sys_rst_o));
endmodule : rwdc_top_props

/* dv/reset_and_watchdog_control_bench.sv */
/*
 Bench of the reset and watchdog controller: register cycles, reset
 sources, watchdog time-outs. Assumes hw/ design and the osc model.
*/
`timescale 1ns/100ps

module reset_and_watchdog_control_bench;
    import rwdc_pkg::*;

    logic       nrst_i = 1'b0, por_i = 1'b0, ext_rst_n_i = 1'b1, bod_low_i = 1'b0;
    logic       scan_rst_i = 1'b0, wd_always_on_fuse_i = 1'b0, wd_restart_i = 1'b0;
    logic       wd_irq_ack_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [3:0] reg_addr_i = 4'h0, adr;
    logic [2:0] bod_fuse = 3'h0;
    logic [1:0] sut_fuse = 2'h0;
    logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, want_v;
    logic       mclk_i, wd_osc_i, io_rst_o, sys_rst_o, wd_irq_o, rd_pend;
    logic [7:0] exp_q[$];
    int         fail_count, n_compared, i;
    int         kind[6] = '{1, 1, 2, 2, 3, 0};
    int         len[6] = '{200, 0, 300, 150, 10, 10};
    logic [7:0] flg[6] = '{8'h02, 8'h00, 8'h04, 8'h00, 8'h10, 8'h01};

    // A four-cycle delay unit keeps each release a few cycles
    rwdc_top #(.DLY_UNIT_CYC(4)) DUT (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .por_i(por_i), .ext_rst_n_i(ext_rst_n_i),
        .bod_low_i(bod_low_i), .scan_rst_i(scan_rst_i), .wd_osc_i(wd_osc_i),
        .brownout_level_fuse_i(bod_fuse), .startup_time_fuse_i(sut_fuse),
        .clock_select_fuse_i(4'h0), .wd_always_on_fuse_i(wd_always_on_fuse_i),
        .wd_restart_i(wd_restart_i), .wd_irq_ack_i(wd_irq_ack_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .io_rst_o(io_rst_o),
        .sys_rst_o(sys_rst_o), .wd_irq_o(wd_irq_o)
    );

    // Six system cycles per tick: time-out near 12288 cycles
    rwdc_osc_model #(.HALF_NS(24)) u_osc (.osc_o(wd_osc_i));

    // 125 MHz system clock
    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end

    task automatic end_sim();
        if (fail_count == 0 && n_compared > 0 && exp_q.size() == 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        n_compared++;
        if (got !== want) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, want);
        end
    endtask : chk

    // One bus cycle; strobes hold until the next call
    task automatic bus(input logic w, r, input logic [3:0] ad, input logic [7:0] d);
        reg_wr_i <= w;
        reg_rd_i <= r;
        reg_addr_i <= ad;
        reg_wdata_i <= d;
        @(posedge mclk_i);
    endtask : bus

    task automatic idle();
        bus(1'b0, 1'b0, 4'h0, 8'h00);
    endtask : idle

    task automatic wr(input logic [3:0] ad, input logic [7:0] d);
        bus(1'b1, 1'b0, ad, d);
    endtask : wr

    task automatic rd(input logic [3:0] ad, input logic [7:0] want);
        exp_q.push_back(want);
        bus(1'b0, 1'b1, ad, 8'h00);
    endtask : rd

    // One-cycle restart or vector acknowledge
    task automatic strobe(input logic ack);
        if (ack)
            wd_irq_ack_i <= 1'b1;
        else
            wd_restart_i <= 1'b1;
        idle();
        wd_irq_ack_i <= 1'b0;
        wd_restart_i <= 1'b0;
    endtask : strobe

    // Bounded wait on sys_rst_o (0) or wd_irq_o (1)
    task automatic wait_for(input int w, input logic v, input int lim);
        for (int k = 0; k < lim; k++) begin
            idle();
            if (((w == 0) ? sys_rst_o : wd_irq_o) === v)
                return;
        end
        fail_count++;
        $display("[FAIL] %0t wait ran out", $time);
        end_sim();
    endtask : wait_for

    task automatic src(input int k, input logic v);
        case (k)
            0: por_i <= v;
            1: ext_rst_n_i <= !v;
            2: bod_low_i <= v;
            default: scan_rst_i <= v;
        endcase
    endtask : src

    // Read data stand only in the cycle after the strobe
    always @(posedge mclk_i) rd_pend <= reg_rd_i;
    always @(negedge mclk_i) begin
        if (rd_pend === 1'b1) begin
            want_v = exp_q.pop_front();
            chk(reg_rdata_o, want_v);
        end
    end

    initial begin
        void'($urandom(32'hda3d));
        repeat (20) @(posedge mclk_i);
        nrst_i <= 1'b1;
        wait_for(0, 1'b0, 200);
        rd(4'h1, 8'h01);
        wr(4'h1, 8'h00);
        adr = 4'h2 + 4'($urandom_range(13));
        wr(adr, 8'($urandom));
        rd(adr, 8'h00);
        // Timed change back to back, then the window left to lapse
        wr(4'h0, 8'h18);
        rd(4'h0, 8'h18);
        wr(4'h0, 8'h21);
        rd(4'h0, 8'h21);
        wr(4'h0, 8'h18);
        repeat (3) idle();
        rd(4'h0, 8'h39);
        rd(4'h0, 8'h29);
        wr(4'h0, 8'h01);
        rd(4'h0, 8'h29);
        // Interrupt mode kept alive by restarts, then left to expire
        wr(4'h0, 8'h18);
        wr(4'h0, 8'h40);
        repeat (15) begin
            repeat (1000) idle();
            strobe(1'b0);
            chk({7'h00, wd_irq_o}, 8'h00);
        end
        wait_for(1, 1'b1, 14000);
        rd(4'h0, 8'hc0);
        wr(4'h0, 8'hc0);
        rd(4'h0, 8'h40);
        wait_for(1, 1'b1, 14000);
        strobe(1'b1);
        rd(4'h0, 8'h40);
        // Combined mode: bounded period, interrupt, then reset
        wr(4'h0, 8'h48);
        strobe(1'b0);
        repeat (11500) idle();
        chk({7'h00, wd_irq_o}, 8'h00);
        wait_for(1, 1'b1, 1500);
        rd(4'h0, 8'h88);
        wait_for(0, 1'b1, 14000);
        wait_for(0, 1'b0, 200);
        rd(4'h1, 8'h08);
        rd(4'h0, 8'h08);
        wr(4'h0, 8'h18);
        wr(4'h0, 8'h00);
        rd(4'h0, 8'h08);
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h18);
        wr(4'h0, 8'h00);
        rd(4'h0, 8'h00);
        // Always-on fuse locks reset mode
        wd_always_on_fuse_i <= 1'b1;
        repeat (3) idle();
        wr(4'h0, 8'h40);
        rd(4'h0, 8'h08);
        // Fuse must clear both sync stages before the timed change
        wd_always_on_fuse_i <= 1'b0;
        repeat (3) idle();
        wr(4'h0, 8'h18);
        wr(4'h0, 8'h00);
        rd(4'h0, 8'h00);
        // Each pin source in turn; a filtered brown-out dip leaves ports alone
        len[1] = 20 + $urandom_range(100);
        for (i = 0; i < 6; i++) begin
            src(kind[i], 1'b1);
            repeat (len[i]) idle();
            chk({7'h00, io_rst_o}, {7'h00, (kind[i] != 2) || (|flg[i])});
            chk({7'h00, sys_rst_o}, {7'h00, |flg[i]});
            src(kind[i], 1'b0);
            wait_for(0, 1'b0, 400);
            rd(4'h1, flg[i]);
            wr(4'h1, 8'h00);
        end
        // Brown-out fused off, longest start-up time fuse code selected (clock-select bit 3 stays 0)
        bod_fuse <= 3'h7;
        sut_fuse <= 2'h3;
        bod_low_i <= 1'b1;
        repeat (300) idle();
        chk({6'h00, io_rst_o, sys_rst_o}, 8'h00);
        bod_low_i <= 1'b0;
        scan_rst_i <= 1'b1;
        repeat (10) idle();
        scan_rst_i <= 1'b0;
        repeat (20) idle();
        chk({7'h00, sys_rst_o}, 8'h01);
        wait_for(0, 1'b0, 40);
        // Mid-run reset clears control registers and leaves only the power-on cause flag
        nrst_i <= 1'b0;
        repeat (2) idle();
        nrst_i <= 1'b1;
        wait_for(0, 1'b0, 200);
        rd(4'h1, 8'h01);
        rd(4'h0, 8'h00);
        idle();
        end_sim();
    end
endmodule : reset_and_watchdog_control_bench

bind rwdc_top rwdc_top_props #(.DLY_UNIT_CYC(DLY_UNIT_CYC)) u_props (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .por_i(por_i), .ext_rst_n_i(ext_rst_n_i),
    .scan_rst_i(scan_rst_i), .wd_always_on_fuse_i(wd_always_on_fuse_i),
    .wd_irq_ack_i(wd_irq_ack_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .io_rst_o(io_rst_o), .sys_rst_o(sys_rst_o), .wd_irq_o(wd_irq_o)
);
